// *** core/arc_trip_map.svh ***
`ifndef ARC_TRIP_MAP_SVH
`define ARC_TRIP_MAP_SVH

// clock and timing
`define ATB_CLK_MHZ        20
`define ATB_STAMP_US       1000
`define ATB_PCYCLE_US      5000
`define ATB_BLK_LEAD_US    5000
`define ATB_STAMP_CYC      (`ATB_CLK_MHZ * `ATB_STAMP_US)
`define ATB_PCYCLE_CYC     (`ATB_CLK_MHZ * `ATB_PCYCLE_US)

// sizes
`define ATB_ZONES          4
`define ATB_NSTAT          26
`define ATB_NEV            52
`define ATB_NSNS           18
`define ATB_RECS           12
`define ATB_CURW           16
`define ATB_RECW           113

// register byte offsets
`define ATB_CTRL_OFS       8'h00
`define ATB_STATUS_OFS     8'h04
`define ATB_COND_OFS       8'h08
`define ATB_ONMASK_OFS     8'h0C
`define ATB_OFFMASK_OFS    8'h10
`define ATB_INTSTAT_OFS    8'h14
`define ATB_INTCLR_OFS     8'h18
`define ATB_INTEN_OFS      8'h1C
`define ATB_STAMP_OFS      8'h20
`define ATB_RECSEL_OFS     8'h24
`define ATB_REC0_OFS       8'h28
`define ATB_REC1_OFS       8'h2C
`define ATB_REC2_OFS       8'h30
`define ATB_REC3_OFS       8'h34

// field positions
`define ATB_CTRL_FORCE_BIT 0
`define ATB_CTRL_SWBLK_BIT 1
`define ATB_INT_TRIP_BIT   0
`define ATB_INT_BLK_BIT    1
`define ATB_INT_REC_BIT    2

// reset values
`define ATB_MASK_RST       26'h3FFFFFF
`define ATB_INTEN_RST      3'h0

`endif

// *** core/arc_trip_pkg.sv ***
package arc_trip_pkg;
`include "arc_trip_map.svh"

   typedef logic [`ATB_CURW-1:0] cur_t;
   typedef logic [`ATB_RECW-1:0] rec_t;

   typedef struct packed {
      logic [`ATB_NSNS-1:0]  snsS1;
      logic [`ATB_NSNS-1:0]  snsS2;
      logic [3:0]            pickS1;
      logic [3:0]            pickS2;
      logic                  blkS1;
      logic                  blkS2;
      logic [31:0]           cycCnt;
      logic [31:0]           msCnt;
      logic [31:0]           msStamp;
      logic [3:0]            pickPrev;
      logic [3:0]            trip;
      logic [3:0]            blocked;
      logic                  blkSampled;
      logic                  blockNotify;
      logic [15:0]           cond;
      logic [`ATB_NSTAT-1:0] statPrev;
      logic [`ATB_NEV-1:0]   pend;
      cur_t                  snapA;
      cur_t                  snapB;
      cur_t                  snapC;
      cur_t                  snapR;
      logic [2:0]            snapSg;
      logic [7:0]            snapSns;
      logic [1:0]            snapFault;
      logic [31:0]           snapStamp;
      logic                  evValid;
      logic [5:0]            evCode;
      logic [31:0]           evStamp;
      cur_t                  evCurA;
      cur_t                  evCurB;
      cur_t                  evCurC;
      cur_t                  evCurR;
      logic [1:0]            evFault;
      logic                  recWe;
      logic [3:0]            recWaddr;
      rec_t                  recWdata;
      logic [3:0]            wrPtr;
      logic [3:0]            recCnt;
      logic [3:0]            recSel;
      logic                  forceEn;
      logic                  swBlock;
      logic [`ATB_NSTAT-1:0] onMask;
      logic [`ATB_NSTAT-1:0] offMask;
      logic [2:0]            intStat;
      logic [2:0]            intEn;
      logic                  irq;
      logic                  pready;
      logic                  pslverr;
      logic [31:0]           prdata;
   } atb_state_s;

endpackage : arc_trip_pkg

// *** core/op_record_mem.sv ***
`timescale 1ns/1ns
module op_record_mem #(
   parameter int WIDTH = 113,
   parameter int DEPTH = 12
) (
   // clock
   input  wire logic             mclk,
   // write side
   input  wire logic             we,
   input  wire logic [3:0]       waddr,
   input  wire logic [WIDTH-1:0] wdata,
   // read side
   input  wire logic [3:0]       raddr,
   output logic      [WIDTH-1:0] rdata
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0]            rdata;
   } mem_s;

   mem_s mem_r;
   mem_s mem_nxt;

   // contents need no reset: the record count says what is valid
   always_comb begin
      mem_nxt = mem_r;
      if (we && (waddr < 4'(DEPTH))) begin
         mem_nxt.mem[waddr] = wdata;
      end
      mem_nxt.rdata = (raddr < 4'(DEPTH)) ? mem_r.mem[raddr] : '0;
   end

   always_ff @(posedge mclk) begin
      mem_r <= mem_nxt;
   end

   assign rdata = mem_r.rdata;
endmodule : op_record_mem

// *** core/arc_trip_block_event_logger.sv ***
`timescale 1ns/1ns
`include "arc_trip_map.svh"

module arc_trip_block_event_logger #(
   parameter int STAMP_CYC  = `ATB_STAMP_CYC,
   parameter int PCYCLE_CYC = `ATB_PCYCLE_CYC
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // pick-up element and blocking matrix pins
   input  wire logic [3:0]  zonePickup,
   input  wire logic        blockIn,
   // sensor status pins
   input  wire logic        phCurrBlocked,
   input  wire logic        phCurrStart,
   input  wire logic        resCurrBlocked,
   input  wire logic        resCurrStart,
   input  wire logic [3:0]  lightDetect,
   input  wire logic [3:0]  pressureDetect,
   input  wire logic        aux_binary_input,
   input  wire logic [3:0]  sensorFault,
   input  wire logic        ioUnitFault,
   // process data from measurement logic, same clock
   input  wire logic [15:0] curA,
   input  wire logic [15:0] curB,
   input  wire logic [15:0] curC,
   input  wire logic [15:0] curRes,
   input  wire logic [2:0]  setting_group_index,
   // trip and blocked outputs
   output logic [3:0]       tripOut,
   output logic [3:0]       blockedOut,
   output logic             blockNotify,
   // event buffer port
   output logic             evValid,
   input  wire logic        evReady,
   output logic [5:0]       evCode,
   output logic [31:0]      evStamp,
   output logic [15:0]      evCurA,
   output logic [15:0]      evCurB,
   output logic [15:0]      evCurC,
   output logic [15:0]      evCurR,
   output logic [1:0]       evFault,
   // interrupt
   output logic             irq
);
   arc_trip_pkg::atb_state_s st_r;
   arc_trip_pkg::atb_state_s st_nxt;
   arc_trip_pkg::rec_t       recRdata;

   logic [3:0]              rdAddr;
   logic [4:0]              rdSum;
   logic [`ATB_NSTAT-1:0]   statNow;
   logic [`ATB_NSTAT-1:0]   selMask;
   logic [`ATB_NEV-1:0]     pendWork;
   logic [5:0]              pick;
   logic                    pickFound;
   logic                    tick;
   logic                    blkNow;
   logic                    tripNew;
   logic                    blkNew;
   logic                    recNew;
   logic                    setup;
   logic                    access;
   logic [31:0]             rdVal;
   logic                    rdOk;

   // record read address, 0 selects the newest record
   always_comb begin
      rdSum = 5'(st_r.wrPtr) + 5'(`ATB_RECS) - 5'd1 - 5'(st_r.recSel);
      if (rdSum >= 5'(`ATB_RECS)) begin
         rdSum = rdSum - 5'(`ATB_RECS);
      end
      rdAddr = rdSum[3:0];
   end

   op_record_mem #(
      .WIDTH (`ATB_RECW),
      .DEPTH (`ATB_RECS)
   ) u_rec (
      .mclk  (mclk),
      .we    (st_r.recWe),
      .waddr (st_r.recWaddr),
      .wdata (st_r.recWdata),
      .raddr (rdAddr),
      .rdata (recRdata)
   );

   always_comb begin
      st_nxt   = st_r;
      tripNew  = 1'b0;
      blkNew   = 1'b0;
      recNew   = 1'b0;
      pick     = 6'h00;
      pickFound = 1'b0;
      blkNow   = 1'b0;
      selMask  = '0;
      rdVal    = 32'h00000000;
      rdOk     = 1'b1;
      statNow  = '0;
      // pins pass two flops before use
      st_nxt.snsS1  = {ioUnitFault, sensorFault, aux_binary_input,
                       pressureDetect, lightDetect, resCurrStart,
                       resCurrBlocked, phCurrStart, phCurrBlocked};
      st_nxt.snsS2  = st_r.snsS1;
      st_nxt.pickS1 = zonePickup;
      st_nxt.pickS2 = st_r.pickS1;
      st_nxt.blkS1  = blockIn;
      st_nxt.blkS2  = st_r.blkS1;

      // millisecond stamp
      if (st_r.msCnt >= 32'(STAMP_CYC - 1)) begin
         st_nxt.msCnt   = 32'h00000000;
         st_nxt.msStamp = st_r.msStamp + 32'h00000001;
      end else begin
         st_nxt.msCnt = st_r.msCnt + 32'h00000001;
      end

      // program cycle timer
      tick = (st_r.cycCnt >= 32'(PCYCLE_CYC - 1));
      st_nxt.cycCnt = tick ? 32'h00000000 : st_r.cycCnt + 32'h00000001;
      st_nxt.blockNotify = 1'b0;

      // one event drained per clock, stalled by the buffer
      pendWork = st_r.pend;
      if (!st_r.evValid || evReady) begin
         st_nxt.evValid = 1'b0;
         st_nxt.recWe   = 1'b0;
         for (int k = `ATB_NEV - 1; k >= 0; k--) begin
            if (pendWork[k]) begin
               pick      = 6'(k);
               pickFound = 1'b1;
            end
         end
         if (pickFound) begin
            pendWork[pick] = 1'b0;
            selMask = pick[0] ? st_r.offMask : st_r.onMask;
            if (selMask[pick[5:1]]) begin
               st_nxt.evValid = 1'b1;
               st_nxt.evCode  = pick;
               st_nxt.evStamp = st_r.snapStamp;
               st_nxt.evCurA  = st_r.snapA;
               st_nxt.evCurB  = st_r.snapB;
               st_nxt.evCurC  = st_r.snapC;
               st_nxt.evCurR  = st_r.snapR;
               st_nxt.evFault = st_r.snapFault;
            end
            // zone trip or block ON is an operation, mask or not
            if (!pick[0] && (pick < 6'd16)) begin
               recNew          = 1'b1;
               st_nxt.recWe    = 1'b1;
               st_nxt.recWaddr = st_r.wrPtr;
               st_nxt.recWdata = {st_r.snapStamp, pick, st_r.snapA,
                                  st_r.snapB, st_r.snapC, st_r.snapR,
                                  st_r.snapSns, st_r.snapSg};
               st_nxt.wrPtr = (st_r.wrPtr == 4'(`ATB_RECS - 1)) ?
                              4'h0 : st_r.wrPtr + 4'h1;
               if (st_r.recCnt != 4'(`ATB_RECS)) begin
                  st_nxt.recCnt = st_r.recCnt + 4'h1;
               end
            end
         end
      end
      st_nxt.pend = pendWork;
      if (st_r.recWe && !st_nxt.recWe) begin
         st_nxt.recWe = 1'b0;
      end

      // decision once per program cycle
      if (tick) begin
         blkNow = st_r.forceEn ? st_r.swBlock : st_r.blkS2;
         st_nxt.blkSampled = blkNow;
         for (int z = 0; z < `ATB_ZONES; z++) begin
            if (st_r.pickS2[z] && !st_r.pickPrev[z]) begin
               if (!blkNow) begin
                  st_nxt.trip[z] = 1'b1;
                  st_nxt.cond[z*4 +: 4] = {1'b1, 3'(2*z)};
                  tripNew = 1'b1;
               end else begin
                  st_nxt.blocked[z] = 1'b1;
                  st_nxt.cond[z*4 +: 4] = {1'b1, 3'(2*z+1)};
                  blkNew = 1'b1;
               end
            end else if (!st_r.pickS2[z]) begin
               st_nxt.trip[z]    = 1'b0;
               st_nxt.blocked[z] = 1'b0;
            end
            statNow[2*z]   = st_nxt.trip[z];
            statNow[2*z+1] = st_nxt.blocked[z];
         end
         st_nxt.blockNotify = blkNew;
         st_nxt.pickPrev    = st_r.pickS2;
         statNow[11:8] = st_r.snsS2[3:0];
         for (int c = 0; c < 4; c++) begin
            statNow[12+2*c] = st_r.snsS2[4+c];
            statNow[13+2*c] = st_r.snsS2[8+c];
         end
         statNow[25:20] = st_r.snsS2[17:12];
         // edges only, set wins over the drain clear
         for (int i = 0; i < `ATB_NSTAT; i++) begin
            if (statNow[i] && !st_r.statPrev[i]) begin
               st_nxt.pend[2*i] = 1'b1;
            end
            if (!statNow[i] && st_r.statPrev[i]) begin
               st_nxt.pend[2*i+1] = 1'b1;
            end
         end
         st_nxt.statPrev = statNow;
         // one snapshot per cycle; a stalled buffer drains lowest code first, with the latest snapshot
         if (statNow != st_r.statPrev) begin
            st_nxt.snapStamp = st_r.msStamp;
            st_nxt.snapA     = curA;
            st_nxt.snapB     = curB;
            st_nxt.snapC     = curC;
            st_nxt.snapR     = curRes;
            st_nxt.snapSg    = setting_group_index;
            st_nxt.snapSns   = {st_r.snsS2[11:8], st_r.snsS2[7:4]};
            st_nxt.snapFault = {st_r.snsS2[3], st_r.snsS2[1]};
         end
      end

      // apb: answer registered in setup, taken in access
      setup  = psel && !penable && !st_r.pready;
      access = psel && penable && st_r.pready;
      unique case (paddr)
         `ATB_CTRL_OFS:    rdVal = {30'h0, st_r.swBlock, st_r.forceEn};
         `ATB_STATUS_OFS:  rdVal = {16'h0, st_r.recCnt, 3'h0,
                                    st_r.blkSampled, st_r.blocked,
                                    st_r.trip};
         `ATB_COND_OFS:    rdVal = {16'h0, st_r.cond};
         `ATB_ONMASK_OFS:  rdVal = 32'(st_r.onMask);
         `ATB_OFFMASK_OFS: rdVal = 32'(st_r.offMask);
         `ATB_INTSTAT_OFS: rdVal = {29'h0, st_r.intStat};
         `ATB_INTCLR_OFS:  rdVal = 32'h00000000;
         `ATB_INTEN_OFS:   rdVal = {29'h0, st_r.intEn};
         `ATB_STAMP_OFS:   rdVal = st_r.msStamp;
         `ATB_RECSEL_OFS:  rdVal = {28'h0, st_r.recSel};
         `ATB_REC0_OFS:    rdVal = recRdata[112:81];
         `ATB_REC1_OFS:    rdVal = {8'h0, recRdata[10:3], 5'h0,
                                    recRdata[2:0], 2'h0, recRdata[80:75]};
         `ATB_REC2_OFS:    rdVal = {recRdata[58:43], recRdata[74:59]};
         `ATB_REC3_OFS:    rdVal = {recRdata[26:11], recRdata[42:27]};
         default:          rdOk  = 1'b0;
      endcase
      st_nxt.pready = setup;
      if (setup) begin
         st_nxt.prdata  = pwrite ? 32'h00000000 : rdVal;
         st_nxt.pslverr = !rdOk;
      end else if (access) begin
         st_nxt.pslverr = 1'b0;
      end

      // interrupt clear first, then hardware sets win
      if (access && pwrite && rdOk) begin
         unique case (paddr)
            `ATB_CTRL_OFS: begin
               st_nxt.forceEn = pwdata[`ATB_CTRL_FORCE_BIT];
               st_nxt.swBlock = pwdata[`ATB_CTRL_SWBLK_BIT];
            end
            `ATB_ONMASK_OFS:  st_nxt.onMask  = pwdata[`ATB_NSTAT-1:0];
            `ATB_OFFMASK_OFS: st_nxt.offMask = pwdata[`ATB_NSTAT-1:0];
            `ATB_INTCLR_OFS:  st_nxt.intStat = st_r.intStat & ~pwdata[2:0];
            `ATB_INTEN_OFS:   st_nxt.intEn   = pwdata[2:0];
            `ATB_STAMP_OFS:   st_nxt.msStamp = pwdata;
            `ATB_RECSEL_OFS:  st_nxt.recSel  = pwdata[3:0];
            default: begin
            end
         endcase
      end
      if (tripNew) st_nxt.intStat[`ATB_INT_TRIP_BIT] = 1'b1;
      if (blkNew)  st_nxt.intStat[`ATB_INT_BLK_BIT]  = 1'b1;
      if (recNew)  st_nxt.intStat[`ATB_INT_REC_BIT]  = 1'b1;
      st_nxt.irq = |(st_nxt.intStat & st_nxt.intEn);

      if (!rstn) begin
         st_nxt         = '0;
         st_nxt.onMask  = `ATB_MASK_RST;
         st_nxt.offMask = `ATB_MASK_RST;
         st_nxt.intEn   = `ATB_INTEN_RST;
      end
   end

   always_ff @(posedge mclk) begin
      st_r <= st_nxt;
   end

   assign pready      = st_r.pready;
   assign prdata      = st_r.prdata;
   assign pslverr     = st_r.pslverr;
   assign tripOut     = st_r.trip;
   assign blockedOut  = st_r.blocked;
   assign blockNotify = st_r.blockNotify;
   assign evValid     = st_r.evValid;
   assign evCode      = st_r.evCode;
   assign evStamp     = st_r.evStamp;
   assign evCurA      = st_r.evCurA;
   assign evCurB      = st_r.evCurB;
   assign evCurC      = st_r.evCurC;
   assign evCurR      = st_r.evCurR;
   assign evFault     = st_r.evFault;
   assign irq         = st_r.irq;
endmodule : arc_trip_block_event_logger

// *** dv/arc_trip_props.sv ***
`timescale 1ns/1ns
module arc_trip_props #(
   parameter int PCYCLE_CYC = 16
) (
   // clock and reset
   input wire logic        mclk,
   input wire logic        rstn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   // outputs under watch
   input wire logic [3:0]  tripOut,
   input wire logic [3:0]  blockedOut,
   input wire logic        blockNotify,
   input wire logic        evValid,
   input wire logic        evReady,
   input wire logic [5:0]  evCode,
   input wire logic [31:0] evStamp
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);

   logic [7:0] prevOut_r;
   int         gap_r;

   // gap saturates so a long quiet spell cannot wrap
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         prevOut_r <= 8'h00;
         gap_r     <= 0;
      end else begin
         prevOut_r <= {blockedOut, tripOut};
         if ({blockedOut, tripOut} != prevOut_r)
            gap_r <= 0;
         else if (gap_r < 1000)
            gap_r <= gap_r + 1;
      end
   end

   apb_ready_a: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   ready_once_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   out_gap_a: assert property (
      {blockedOut, tripOut} != prevOut_r |-> gap_r >= PCYCLE_CYC - 1)
      else $error("outputs changed between program cycles");
   no_dual_a: assert property (!(|(tripOut & blockedOut)))
      else $error("zone both tripped and blocked");
   notify_blk_a: assert property (
      blockNotify |-> ##[0:1] (|blockedOut))
      else $error("notify without blocked zone");
   notify_pulse_a: assert property (blockNotify |=> !blockNotify)
      else $error("notify longer than one cycle");
   ev_hold_a: assert property (
      evValid && !evReady |=> evValid && $stable(evCode) && $stable(evStamp))
      else $error("event dropped or changed while stalled");
   trip_ev_a: assert property (
      $rose(tripOut[0]) |-> ##[0:60] evValid)
      else $error("no event after zone trip");
   ev_range_a: assert property (evValid |-> evCode < 6'h34)
      else $error("event code out of range");
endmodule : arc_trip_props

bind arc_trip_block_event_logger arc_trip_props #(
   .PCYCLE_CYC(PCYCLE_CYC)
) u_arc_trip_props (
   .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
   .pready(pready), .tripOut(tripOut), .blockedOut(blockedOut),
   .blockNotify(blockNotify), .evValid(evValid), .evReady(evReady),
   .evCode(evCode), .evStamp(evStamp)
);

// *** dv/event_buffer_model.sv ***
`timescale 1ns/1ns
module event_buffer_model (
   // clock, reset, mode
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        slow,
   // event port
   input  wire logic        evValid,
   output logic             evReady,
   input  wire logic [5:0]  evCode,
   input  wire logic [31:0] evStamp,
   input  wire logic [15:0] evCurA,
   // log
   output int               evCount,
   output logic [5:0]       lastCode,
   output logic [31:0]      lastStamp,
   output logic [15:0]      lastCurA
);
   logic [1:0] waitCnt_r;

   // slow mode stalls each event three cycles to load the holding logic
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         evReady   <= 1'b0;
         waitCnt_r <= 2'h0;
         evCount   <= 0;
         lastCode  <= 6'h3F;
      end else begin
         if (evValid && evReady) begin
            evCount   <= evCount + 1;
            lastCode  <= evCode;
            lastStamp <= evStamp;
            lastCurA  <= evCurA;
         end
         waitCnt_r <= (evValid && !evReady) ? waitCnt_r + 2'h1 : 2'h0;
         evReady   <= !slow || (waitCnt_r == 2'h2);
      end
   end
endmodule : event_buffer_model

// *** dv/tb_top.sv ***
`timescale 1ns/1ns
`include "arc_trip_map.svh"
module tb_top;
   localparam int PC = 16;
   logic mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, blockIn = 1'b0, slow = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  zonePickup = 4'h0;
   logic [17:0] sts = 18'h0;
   logic [15:0] curA = 16'h0A5A;
   logic        pready, pslverr, blockNotify, evValid, evReady, irq, err;
   logic [31:0] prdata, evStamp, lastStamp, rd, stamp0;
   logic [3:0]  tripOut, blockedOut;
   logic [15:0] evCurA, lastCurA, evCurR, lastCurR;
   logic [1:0]  evFault, lastFault;
   logic [5:0]  evCode, lastCode;
   logic [7:0]  outs;
   int          n_fail = 0, checks = 0, evCount, expN, cyc = 0;
   int          nNotify = 0;

   assign outs = {blockedOut, tripOut};

   arc_trip_block_event_logger #(.STAMP_CYC(4), .PCYCLE_CYC(PC))
   u_arc_trip_block_event_logger (
      .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .zonePickup(zonePickup),
      .blockIn(blockIn), .phCurrBlocked(sts[0]), .phCurrStart(sts[1]),
      .resCurrBlocked(sts[2]), .resCurrStart(sts[3]),
      .lightDetect({sts[10], sts[8], sts[6], sts[4]}),
      .pressureDetect({sts[11], sts[9], sts[7], sts[5]}),
      .aux_binary_input(sts[12]), .sensorFault(sts[16:13]),
      .ioUnitFault(sts[17]), .curA(curA), .curB(16'h0B5B),
      .curC(16'h0C5C), .curRes(16'h0D5D), .setting_group_index(3'h5),
      .tripOut(tripOut), .blockedOut(blockedOut),
      .blockNotify(blockNotify), .evValid(evValid), .evReady(evReady),
      .evCode(evCode), .evStamp(evStamp), .evCurA(evCurA), .evCurB(),
      .evCurC(), .evCurR(evCurR), .evFault(evFault), .irq(irq)
   );

   // fields the buffer model does not log, taken at the handshake
   always @(posedge mclk) begin
      if (evValid && evReady) begin
         lastFault <= evFault;
         lastCurR  <= evCurR;
      end
      if (blockNotify)
         nNotify <= nNotify + 1;
   end

   event_buffer_model u_event_buffer_model (
      .mclk(mclk), .rstn(rstn), .slow(slow), .evValid(evValid),
      .evReady(evReady), .evCode(evCode), .evStamp(evStamp),
      .evCurA(evCurA), .evCount(evCount), .lastCode(lastCode),
      .lastStamp(lastStamp), .lastCurA(lastCurA)
   );

   initial forever #25 mclk = ~mclk;

   task close_out;
      if (n_fail == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // master holds everything until pready is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rdChk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdChk

   task ticks(input int n);
      repeat (n * PC) @(posedge mclk);
   endtask : ticks

   task evChk(input int n, input int code);
      ticks(3);
      chk(evCount, n);
      chk(lastCode, code);
   endtask : evChk

   task waitOut(input int b);
      int n;
      n = 0;
      while (outs[b] !== 1'b1 && n < 3 * PC) begin
         @(posedge mclk);
         n++;
      end
   endtask : waitOut

   initial begin
      forever begin
         @(posedge mclk);
         cyc++;
         if (cyc == 8000) begin
            n_fail++;
            close_out();
         end
      end
   end

   initial begin
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      rdChk(`ATB_ONMASK_OFS, 32'h03FFFFFF);
      rdChk(`ATB_OFFMASK_OFS, 32'h03FFFFFF);
      rdChk(`ATB_INTEN_OFS, 32'h0);
      apb(1'b1, 8'h40, 32'h1);
      chk(err, 1'b1);
      apb(1'b1, `ATB_STATUS_OFS, 32'hFFFF);
      rdChk(`ATB_STATUS_OFS, 32'h0);
      apb(1'b1, `ATB_INTEN_OFS, 32'h7);
      zonePickup[0] <= 1'b1;
      waitOut(0);
      chk(outs, 8'h01);
      evChk(1, 0);
      chk(lastCurA, 16'h0A5A);
      chk(lastCurR, 16'h0D5D);
      chk(irq, 1'b1);
      rdChk(`ATB_INTSTAT_OFS, 32'h5);
      apb(1'b1, `ATB_INTCLR_OFS, 32'h7);
      rdChk(`ATB_INTSTAT_OFS, 32'h0);
      rdChk(`ATB_INTCLR_OFS, 32'h0);
      chk(irq, 1'b0);
      apb(1'b1, `ATB_INTEN_OFS, 32'h0);
      blockIn <= 1'b1;
      slow <= 1'b1;
      ticks(2);
      zonePickup[1] <= 1'b1;
      waitOut(5);
      chk(outs, 8'h21);
      evChk(2, 6);
      chk(nNotify, 1);
      chk(irq, 1'b0);
      rdChk(`ATB_STATUS_OFS, 32'h2121);
      rdChk(`ATB_COND_OFS, 32'hB8);
      apb(1'b1, `ATB_INTEN_OFS, 32'h2);
      rdChk(`ATB_INTSTAT_OFS, 32'h6);
      chk(irq, 1'b1);
      apb(1'b1, `ATB_INTCLR_OFS, 32'h7);
      zonePickup <= 4'h0;
      blockIn <= 1'b0;
      evChk(4, 7);
      chk(outs, 8'h00);
      apb(1'b1, `ATB_CTRL_OFS, 32'h3);
      ticks(1);
      zonePickup[2] <= 1'b1;
      waitOut(6);
      chk(outs, 8'h40);
      zonePickup <= 4'h0;
      apb(1'b1, `ATB_CTRL_OFS, 32'h1);
      blockIn <= 1'b1;
      ticks(1);
      zonePickup[3] <= 1'b1;
      waitOut(3);
      chk(outs, 8'h08);
      zonePickup <= 4'h0;
      blockIn <= 1'b0;
      evChk(8, 13);
      chk(nNotify, 2);
      // masked: ON of phase start, OFF of aux input
      apb(1'b1, `ATB_ONMASK_OFS, 32'h03FFFDFF);
      apb(1'b1, `ATB_OFFMASK_OFS, 32'h03EFFFFF);
      expN = 8;
      for (int i = 0; i < 18; i++) begin
         sts[i] <= 1'b1;
         ticks(3);
         stamp0 = lastStamp;
         expN = expN + (i != 1);
         chk(evCount, expN);
         if (i != 1)
            chk(lastCode, 16 + 2 * i);
         if (i == 3)
            chk(lastFault, 2'h2);
         sts[i] <= 1'b0;
         ticks(3);
         expN = expN + (i != 12);
         chk(evCount, expN);
         if (i != 12)
            chk(lastCode, 17 + 2 * i);
         chk(lastStamp > stamp0, i != 12);
      end
      for (int i = 0; i < 10; i++) begin
         curA <= 16'h1000 + 16'(i);
         zonePickup[0] <= 1'b1;
         ticks(2);
         zonePickup[0] <= 1'b0;
         ticks(2);
      end
      rdChk(`ATB_STATUS_OFS, 32'hC000);
      apb(1'b1, `ATB_RECSEL_OFS, 32'h0);
      rdChk(`ATB_REC1_OFS, 32'h500);
      rdChk(`ATB_REC2_OFS, 32'h0B5B1009);
      rdChk(`ATB_REC3_OFS, 32'h0D5D0C5C);
      apb(1'b1, `ATB_RECSEL_OFS, 32'hB);
      rdChk(`ATB_REC1_OFS, 32'h50A);
      rdChk(`ATB_REC2_OFS, 32'h0B5B0A5A);
      close_out();
   end
endmodule : tb_top
